//--- core/dac_volume_and_irq_pkg.sv
// Overview of operation
// RULE1 - attenuation mode 0 ramps volume and mute changes softly, 1 applies them at once
// RULE2 - each channel mute bit set silences its dac channel, clear passes it
// RULE3 - ramp bit 0 holds common level at half supply, 1 ramps it to ground
// RULE4 - host sets the common level ramp bit before asserting the reset pin
// RULE5 - each dac power-off bit set shuts its path down, clear keeps it powered
// RULE6 - mute delay codes 0..3 give 1, 4, 16, 64 base periods per mute step
// RULE7 - mute and unmute ramps move the level in steps of 6.02/64 dB
// RULE8 - minimum delay code n gives two to the n base periods before a transition
// RULE9 - maximum delay code n gives two to the n base periods at most
// RULE10 - master and channel volumes are 8 bits, 0.38 dB per count, 0x10 unity
// RULE11 - code zero gives +6.02 dB, top codes give the deepest attenuation
// RULE12 - irq mode 0 sets mask bits for flags found on a notification read
// RULE13 - polarity 00 active high, 01 active low, 10 open drain, 11 reserved
// RULE14 - mask bit 0 lets its event drive the irq pin, 1 blocks it
// RULE15 - an unintended write into test mode raises the test entry fault
// RULE16 - framing, speed or role change while any path is powered raises port fault
// RULE17 - slave ratio change while powered raises both port and clocking faults
// RULE18 - master clock change in master operation raises neither fault
// RULE19 - notification flags stay set until the host clears the register
// RULE20 - irq pin is active while any unmasked notification flag is set
package dac_volume_and_irq_pkg;
    // =========================================================
    // register offsets
    localparam logic [7:0] OFS_MUTE_MODE = 8'h14;
    localparam logic [7:0] OFS_POWER_VQ = 8'h15;
    localparam logic [7:0] OFS_RAMP_TIMING = 8'h16;
    localparam logic [7:0] OFS_MASTER_VOL = 8'h17;
    localparam logic [7:0] OFS_CH1_VOL = 8'h18;
    localparam logic [7:0] OFS_CH2_VOL = 8'h19;
    localparam logic [7:0] OFS_CH3_VOL = 8'h1A;
    localparam logic [7:0] OFS_CH4_VOL = 8'h1B;
    localparam logic [7:0] OFS_IRQ_CONFIG = 8'h1E;
    localparam logic [7:0] OFS_IRQ_MASK_A = 8'h1F;
    localparam logic [7:0] OFS_NOTIFY_A = 8'h21;
    // =========================================================
    // field positions
    localparam int BIT_ATT_MODE = 6;
    localparam int BIT_COMMON_LEVEL_RAMP_DOWN = 7;
    localparam int BIT_IRQ_MODE = 7;
    localparam int POS_IRQ_POL = 5;
    localparam int POS_MUTE_DELAY = 6;
    localparam int POS_MIN_DELAY = 3;
    localparam int POS_MAX_DELAY = 0;
    localparam int BIT_TEST_FAULT = 7;
    localparam int BIT_PORT_FAULT = 6;
    localparam int BIT_CLOCK_FAULT = 5;
    // readable bits of each register, reserved bits read zero
    localparam logic [7:0] USED_MUTE_MODE = 8'h4F;
    localparam logic [7:0] USED_POWER_VQ = 8'h8F;
    localparam logic [7:0] USED_IRQ_CONFIG = 8'hE0;
    localparam logic [7:0] USED_FLAGS = 8'hEF;
    // =========================================================
    // reset values
    localparam logic [7:0] RST_MUTE_MODE = 8'h00;
    localparam logic [7:0] RST_POWER_VQ = 8'h00;
    localparam logic [7:0] RST_RAMP_TIMING = 8'h00;
    localparam logic [7:0] RST_VOLUME = 8'h10;
    localparam logic [7:0] RST_IRQ_CONFIG = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;
    // =========================================================
    // attenuation scale: four fine steps of 6.02/64 dB per volume count
    localparam int LEVEL_W = 11;
    localparam logic [LEVEL_W-1:0] MUTE_LEVEL = 11'h7FF;
    localparam logic [1:0] POL_HIGH = 2'h0;
    localparam logic [1:0] POL_LOW = 2'h1;
    localparam logic [1:0] POL_OPEN_DRAIN = 2'h2;
    // base period of the ramp timer in clock cycles
    localparam int BASE_PERIOD_CYCLES = 512;
endpackage

//--- core/volume_ramp_channel.sv
`timescale 1ns/1ps
module volume_ramp_channel
    import dac_volume_and_irq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_base_tick,
    input wire logic i_immediate,
    input wire logic i_mute,
    input wire logic [LEVEL_W-1:0] i_target,
    input wire logic [1:0] i_mute_delay,
    input wire logic [2:0] i_min_delay,
    input wire logic [2:0] i_max_delay,
    output logic [LEVEL_W-1:0] o_level,
    output logic o_silent
);
    logic [LEVEL_W-1:0] level_reg;
    logic [LEVEL_W-1:0] goal;
    logic [7:0] wait_reg;
    logic [7:0] limit;
    logic [2:0] eff_delay;
    logic mute_prev_reg;
    logic mute_ramp_reg;
    logic silent_reg;
    logic step_due;

    // =========================================================
    // step pacing
    // a muted channel heads for the floor level, otherwise for its volume
    assign goal = i_mute ? MUTE_LEVEL : i_target; // RULE2
    // min above max is clamped so a non-mute wait never exceeds the maximum
    assign eff_delay = (i_min_delay > i_max_delay) ? i_max_delay : i_min_delay; // RULE8 RULE9
    // mute ramps use 1/4/16/64 periods, others two to the n periods
    assign limit = mute_ramp_reg ? (8'h01 << {i_mute_delay, 1'b0}) : (8'h01 << eff_delay); // RULE6
    assign step_due = i_base_tick && (wait_reg + 8'h01 >= limit);

    // wait counter in base periods
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            wait_reg <= 8'h00;
        else if (i_immediate || level_reg == goal || step_due)
            wait_reg <= 8'h00;
        else if (i_base_tick)
            wait_reg <= wait_reg + 8'h01;
    end

    // soft mode moves the level one fine step of 6.02/64 dB at a time, immediate mode jumps to the goal
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            level_reg <= MUTE_LEVEL;
        else if (i_immediate)
            level_reg <= goal; // RULE1
        else if (step_due && level_reg < goal)
            level_reg <= level_reg + 11'h001; // RULE7
        else if (step_due && level_reg > goal)
            level_reg <= level_reg - 11'h001; // RULE7
    end

    // a mute edge starts a mute ramp; the edge wins over reaching the goal
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            mute_prev_reg <= 1'b0;
            mute_ramp_reg <= 1'b0;
        end
        else
        begin
            mute_prev_reg <= i_mute;
            if (i_mute != mute_prev_reg)
                mute_ramp_reg <= 1'b1;
            else if (level_reg == goal)
                mute_ramp_reg <= 1'b0;
        end
    end

    // silent only once the floor level is reached
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            silent_reg <= 1'b0;
        else
            silent_reg <= i_mute && (level_reg == MUTE_LEVEL); // RULE2
    end

    assign o_level = level_reg;
    assign o_silent = silent_reg;

    // =========================================================
    // checks
    property p_immediate_level;
        @(posedge i_clk) disable iff (!i_arst_n)
        i_immediate |=> (level_reg == $past(goal));
    endproperty
    a_immediate_level: assert property (p_immediate_level) else $error("immediate mode missed goal"); // RULE1

    property p_single_step;
        @(posedge i_clk) disable iff (!i_arst_n)
        (!i_immediate && !$past(i_immediate) && $changed(level_reg)) |->
            (level_reg - $past(level_reg) == 11'h001 || $past(level_reg) - level_reg == 11'h001);
    endproperty
    a_single_step: assert property (p_single_step) else $error("soft ramp step not one unit"); // RULE7

    property p_step_on_tick;
        @(posedge i_clk) disable iff (!i_arst_n)
        (!$past(i_immediate) && $changed(level_reg)) |-> $past(i_base_tick);
    endproperty
    a_step_on_tick: assert property (p_step_on_tick) else $error("soft step off base tick"); // RULE6

    property p_wait_bound;
        @(posedge i_clk) disable iff (!i_arst_n)
        wait_reg < 8'h80;
    endproperty
    a_wait_bound: assert property (p_wait_bound) else $error("wait beyond 128 periods"); // RULE9
endmodule

//--- core/dac_volume_and_irq_control_regs.sv
`timescale 1ns/1ps
module dac_volume_and_irq_control_regs
    import dac_volume_and_irq_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_PERIOD_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    // register access from the control port
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // state of the rest of the device
    input wire logic [3:0] i_adc_path_power_off,
    input wire logic [1:0] i_serial_framing_select,
    input wire logic [1:0] i_speed_mode,
    input wire logic i_controller_role_select,
    input wire logic i_clock_ratio_change,
    input wire logic i_master_clock_change,
    input wire logic i_test_entry,
    input wire logic [3:0] i_converter_overrange,
    // dac path controls
    output logic [LEVEL_W-1:0] o_ch1_attenuation,
    output logic [LEVEL_W-1:0] o_ch2_attenuation,
    output logic [LEVEL_W-1:0] o_ch3_attenuation,
    output logic [LEVEL_W-1:0] o_ch4_attenuation,
    output logic [3:0] o_dac_channel_silence,
    output logic [3:0] o_dac_path_power_off,
    output logic o_common_level_ramp_down,
    // interrupt pin
    output logic o_irq_out,
    output logic o_irq_oe
);
    // the base counter is 12 bits wide, so longer periods cannot be served
    if (BASE_CYCLES < 1 || BASE_CYCLES > 4096)
    begin : g_bad_base_cycles
        $error("BASE_CYCLES must lie in 1..4096");
    end

    logic [7:0] mute_mode_reg;
    logic [7:0] power_vq_reg;
    logic [7:0] ramp_timing_reg;
    logic [7:0] master_vol_reg;
    logic [7:0] ch_vol_reg [4];
    logic [7:0] irq_config_reg;
    logic [7:0] irq_mask_reg;
    logic [7:0] flags_reg;
    logic [7:0] flags_set;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [11:0] base_cnt_reg;
    logic base_tick;
    logic [1:0] framing_prev_reg;
    logic [1:0] speed_prev_reg;
    logic role_prev_reg;
    logic all_powered_off;
    logic port_change;
    logic notify_read;
    logic irq_active;
    logic [LEVEL_W-1:0] ch_level [4];
    logic [3:0] ch_silent;
    logic [1:0] irq_pol;

    // =========================================================
    // register writes
    // each register but the four channel volumes keeps its own process so writes stay easy to audit
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            mute_mode_reg <= RST_MUTE_MODE;
        else if (i_wr_en && i_addr == OFS_MUTE_MODE)
            mute_mode_reg <= i_wdata & USED_MUTE_MODE;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            power_vq_reg <= RST_POWER_VQ;
        else if (i_wr_en && i_addr == OFS_POWER_VQ)
            power_vq_reg <= i_wdata & USED_POWER_VQ;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            ramp_timing_reg <= RST_RAMP_TIMING;
        else if (i_wr_en && i_addr == OFS_RAMP_TIMING)
            ramp_timing_reg <= i_wdata;
    end

    // volumes: full 8-bit codes, 0x10 is unity
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            master_vol_reg <= RST_VOLUME;
        else if (i_wr_en && i_addr == OFS_MASTER_VOL)
            master_vol_reg <= i_wdata; // RULE10
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            for (int k = 0; k < 4; k++)
                ch_vol_reg[k] <= RST_VOLUME;
        end
        else if (i_wr_en)
        begin
            for (int k = 0; k < 4; k++)
                if (i_addr == OFS_CH1_VOL + 8'(k))
                    ch_vol_reg[k] <= i_wdata; // RULE10
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            irq_config_reg <= RST_IRQ_CONFIG;
        else if (i_wr_en && i_addr == OFS_IRQ_CONFIG)
            irq_config_reg <= i_wdata & USED_IRQ_CONFIG;
    end

    // auto masking on a notification read wins over a plain write
    assign notify_read = i_rd_en && i_addr == OFS_NOTIFY_A;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            irq_mask_reg <= RST_IRQ_MASK;
        else if (notify_read && !irq_config_reg[BIT_IRQ_MODE])
            irq_mask_reg <= irq_mask_reg | (flags_reg & USED_FLAGS); // RULE12
        else if (i_wr_en && i_addr == OFS_IRQ_MASK_A)
            irq_mask_reg <= i_wdata & USED_FLAGS;
    end

    // =========================================================
    // fault detection
    // port settings are sampled to spot changes; a change while powered is a fault
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            framing_prev_reg <= 2'h0;
            speed_prev_reg <= 2'h0;
            role_prev_reg <= 1'b0;
        end
        else
        begin
            framing_prev_reg <= i_serial_framing_select;
            speed_prev_reg <= i_speed_mode;
            role_prev_reg <= i_controller_role_select;
        end
    end

    // the first cycle after reset compares against reset values; a powered
    // device with non-zero straps may then flag a spurious port fault
    assign all_powered_off = (&i_adc_path_power_off) && (&power_vq_reg[3:0]);
    assign port_change = (i_serial_framing_select != framing_prev_reg) || (i_speed_mode != speed_prev_reg)
        || (i_controller_role_select != role_prev_reg);

    // master clock changes in master operation are ignored on purpose
    always_comb
    begin
        flags_set = 8'h00;
        flags_set[BIT_TEST_FAULT] = i_test_entry; // RULE15
        flags_set[BIT_PORT_FAULT] = !all_powered_off && (port_change
            || (i_clock_ratio_change && !i_controller_role_select)); // RULE16 RULE17 RULE18
        flags_set[BIT_CLOCK_FAULT] = !all_powered_off && i_clock_ratio_change && !i_controller_role_select; // RULE17
        flags_set[3:0] = i_converter_overrange;
    end

    // sticky flags, cleared by reading them; a new event in that cycle survives
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            flags_reg <= 8'h00;
        else if (notify_read)
            flags_reg <= flags_set; // RULE19
        else
            flags_reg <= flags_reg | flags_set; // RULE19
    end

    // =========================================================
    // register reads
    always_comb
    begin
        rdata_next = rdata_reg;
        if (i_rd_en)
        begin
            unique case (i_addr)
                OFS_MUTE_MODE: rdata_next = mute_mode_reg;
                OFS_POWER_VQ: rdata_next = power_vq_reg;
                OFS_RAMP_TIMING: rdata_next = ramp_timing_reg;
                OFS_MASTER_VOL: rdata_next = master_vol_reg;
                OFS_CH1_VOL: rdata_next = ch_vol_reg[0];
                OFS_CH2_VOL: rdata_next = ch_vol_reg[1];
                OFS_CH3_VOL: rdata_next = ch_vol_reg[2];
                OFS_CH4_VOL: rdata_next = ch_vol_reg[3];
                OFS_IRQ_CONFIG: rdata_next = irq_config_reg;
                OFS_IRQ_MASK_A: rdata_next = irq_mask_reg;
                OFS_NOTIFY_A: rdata_next = flags_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    assign o_rdata = rdata_reg;

    // =========================================================
    // volume ramps
    // one shared base-period timer keeps all four channels in step
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            base_cnt_reg <= 12'h000;
        else if (base_tick)
            base_cnt_reg <= 12'h000;
        else
            base_cnt_reg <= base_cnt_reg + 12'h001;
    end

    assign base_tick = (base_cnt_reg == 12'(BASE_CYCLES - 1));

    // total attenuation is master plus channel, scaled to fine steps
    for (genvar g = 0; g < 4; g++)
    begin : g_ch
        logic [8:0] code_sum;
        assign code_sum = {1'b0, master_vol_reg} + {1'b0, ch_vol_reg[g]}; // RULE11
        volume_ramp_channel u_ramp (
            .i_clk(i_clk),
            .i_arst_n(i_arst_n),
            .i_base_tick(base_tick),
            .i_immediate(mute_mode_reg[BIT_ATT_MODE]), // RULE1
            .i_mute(mute_mode_reg[g]), // RULE2
            .i_target({code_sum, 2'b00}),
            .i_mute_delay(ramp_timing_reg[POS_MUTE_DELAY +: 2]),
            .i_min_delay(ramp_timing_reg[POS_MIN_DELAY +: 3]),
            .i_max_delay(ramp_timing_reg[POS_MAX_DELAY +: 3]),
            .o_level(ch_level[g]),
            .o_silent(ch_silent[g])
        );
    end

    assign o_ch1_attenuation = ch_level[0];
    assign o_ch2_attenuation = ch_level[1];
    assign o_ch3_attenuation = ch_level[2];
    assign o_ch4_attenuation = ch_level[3];
    assign o_dac_channel_silence = ch_silent;
    assign o_dac_path_power_off = power_vq_reg[3:0]; // RULE5
    // the host must set this before pulling reset, which then clears it
    assign o_common_level_ramp_down = power_vq_reg[BIT_COMMON_LEVEL_RAMP_DOWN]; // RULE3 RULE4

    // =========================================================
    // interrupt pin
    assign irq_active = |(flags_reg & ~irq_mask_reg & USED_FLAGS); // RULE14 RULE20
    assign irq_pol = irq_config_reg[POS_IRQ_POL +: 2];

    // reserved polarity releases the pin rather than guessing a level
    always_comb
    begin
        unique case (irq_pol)
            POL_HIGH:
            begin
                o_irq_out = irq_active; // RULE13
                o_irq_oe = 1'b1;
            end
            POL_LOW:
            begin
                o_irq_out = !irq_active; // RULE13
                o_irq_oe = 1'b1;
            end
            POL_OPEN_DRAIN:
            begin
                o_irq_out = 1'b0;
                o_irq_oe = irq_active; // RULE13
            end
            default:
            begin
                o_irq_out = 1'b0;
                o_irq_oe = 1'b0;
            end
        endcase
    end

    // =========================================================
    // checks
    property p_sticky;
        @(posedge i_clk) disable iff (!i_arst_n)
        (!$past(notify_read)) |-> ((flags_reg & $past(flags_reg)) == $past(flags_reg));
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without a read"); // RULE19

    property p_auto_mask;
        @(posedge i_clk) disable iff (!i_arst_n)
        (notify_read && !irq_config_reg[BIT_IRQ_MODE]) |=>
            ((irq_mask_reg & $past(flags_reg & USED_FLAGS)) == $past(flags_reg & USED_FLAGS));
    endproperty
    a_auto_mask: assert property (p_auto_mask) else $error("mask not set on read"); // RULE12

    property p_no_auto_mask;
        @(posedge i_clk) disable iff (!i_arst_n)
        (notify_read && irq_config_reg[BIT_IRQ_MODE] && !i_wr_en) |=> $stable(irq_mask_reg);
    endproperty
    a_no_auto_mask: assert property (p_no_auto_mask) else $error("mask changed in mode 1"); // RULE12

    property p_test_fault;
        @(posedge i_clk) disable iff (!i_arst_n)
        i_test_entry |=> flags_reg[BIT_TEST_FAULT];
    endproperty
    a_test_fault: assert property (p_test_fault) else $error("test entry not flagged"); // RULE15

    property p_port_fault;
        @(posedge i_clk) disable iff (!i_arst_n)
        (port_change && !all_powered_off) |=> flags_reg[BIT_PORT_FAULT];
    endproperty
    a_port_fault: assert property (p_port_fault) else $error("port change not flagged"); // RULE16

    property p_ratio_fault;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_clock_ratio_change && !i_controller_role_select && !all_powered_off) |=>
            (flags_reg[BIT_PORT_FAULT] && flags_reg[BIT_CLOCK_FAULT]);
    endproperty
    a_ratio_fault: assert property (p_ratio_fault) else $error("ratio change not flagged"); // RULE17

    property p_master_clock_quiet;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_master_clock_change && i_controller_role_select && !port_change && !notify_read) |=>
            (flags_reg[BIT_CLOCK_FAULT +: 2] == $past(flags_reg[BIT_CLOCK_FAULT +: 2]));
    endproperty
    a_master_clock_quiet: assert property (p_master_clock_quiet) else $error("master clock flagged"); // RULE18

    property p_irq_level;
        @(posedge i_clk) disable iff (!i_arst_n)
        (irq_pol == POL_LOW) |-> (o_irq_out == !(|(flags_reg & ~irq_mask_reg & USED_FLAGS)));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq pin level wrong"); // RULE13 RULE20

    property p_masked_quiet;
        @(posedge i_clk) disable iff (!i_arst_n)
        ((irq_mask_reg & USED_FLAGS) == USED_FLAGS && irq_pol == POL_OPEN_DRAIN) |-> !o_irq_oe;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked event reached pin"); // RULE14

    property p_power_write;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_wr_en && i_addr == OFS_POWER_VQ) |=>
            (o_dac_path_power_off == $past(i_wdata[3:0]) && o_common_level_ramp_down == $past(i_wdata[7]));
    endproperty
    a_power_write: assert property (p_power_write) else $error("power or ramp bits wrong"); // RULE5 RULE3
endmodule

//--- testbench/host_port_model.sv
`timescale 1ns/1ps
// ==========================================
// host side of the control port
module host_port_model
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    // released lines show the inverse of the last value so no stale copy can pass
    initial
    begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    // one-cycle strobe per byte, launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr_en <= 1'b1;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    // read data is taken once the read edge has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd_en <= 1'b1;
        @(posedge i_clk);
        o_rd_en <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
// ==========================================
// bench with an integer register mirror
module tb;
    logic clk = 1'b0, rst_n = 1'b0, role = 1'b0, wr_en, rd_en, vq, irq, oe;
    logic [1:0] frame = 2'h0, speed = 2'h0;
    logic [3:0] adc_off = 4'h0, sil, pdn;
    logic [6:0] ev = 7'h00;
    logic [7:0] addr, wdata, rdata, v;
    logic [10:0] lv1, lv2, lv3, lv4;
    int mir[256];
    int ofs[11] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1E, 8'h1F, 8'h30};
    int err_total = 0, checked = 0, cyc = 0, m, c;
    host_port_model u_host_port_model (.i_clk(clk), .i_rdata(rdata), .o_wr_en(wr_en), .o_rd_en(rd_en),
        .o_addr(addr), .o_wdata(wdata));
    dac_volume_and_irq_control_regs #(.BASE_CYCLES(4)) u_dac_volume_and_irq_control_regs (.i_clk(clk),
        .i_arst_n(rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .i_adc_path_power_off(adc_off), .i_serial_framing_select(frame), .i_speed_mode(speed),
        .i_controller_role_select(role), .i_clock_ratio_change(ev[5]), .i_master_clock_change(ev[6]),
        .i_test_entry(ev[4]), .i_converter_overrange(ev[3:0]), .o_ch1_attenuation(lv1), .o_ch2_attenuation(lv2),
        .o_ch3_attenuation(lv3), .o_ch4_attenuation(lv4), .o_dac_channel_silence(sil),
        .o_dac_path_power_off(pdn), .o_common_level_ramp_down(vq), .o_irq_out(irq), .o_irq_oe(oe));
    always #20 clk = ~clk;
    // a hung handshake ends the run as a failure
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [10:0] s, input logic [10:0] e);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic w(input int a, input int d);
        u_host_port_model.wr(a[7:0], d[7:0]);
        mir[a] = d;
    endtask
    // reserved bits read zero, unmapped places read zero
    function automatic int xr(input int a);
        case (a)
            8'h14: return mir[a] & 8'h4F;
            8'h15: return mir[a] & 8'h8F;
            8'h1E: return mir[a] & 8'hE0;
            8'h1F, 8'h21: return mir[a] & 8'hEF;
            8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B: return mir[a];
            default: return 0;
        endcase
    endfunction
    // a notification read clears the flags and, in mode 0, copies them into the mask
    task automatic r(input int a);
        u_host_port_model.rd(a[7:0], v);
        chk("rdata", {3'h0, v}, xr(a));
        if (a == 8'h21)
        begin
            if ((mir[8'h1E] & 8'h80) == 0)
                mir[8'h1F] |= mir[8'h21];
            mir[8'h21] = 0;
        end
    endtask
    task automatic pulse(input logic [6:0] p, input int f);
        @(posedge clk);
        ev <= p;
        @(posedge clk);
        ev <= 7'h00;
        mir[8'h21] |= f;
        #1;
    endtask
    task automatic ci();
        logic a;
        int p;
        a = |(mir[8'h21] & ~mir[8'h1F] & 8'hEF);
        p = (mir[8'h1E] >> 5) & 3;
        chk("irq", {irq, oe}, p == 0 ? {a, 1'b1} : p == 1 ? {~a, 1'b1} : p == 2 ? {1'b0, a} : 2'b00);
    endtask
    initial
    begin
        void'($urandom(47153));
        foreach (mir[i]) mir[i] = (i >= 8'h17 && i <= 8'h1B) ? 8'h10 : 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ofs[i]) r(ofs[i]);
        foreach (ofs[i]) begin w(ofs[i], $urandom % 256); r(ofs[i]); end
        chk("pdn", pdn, mir[8'h15] & 8'h0F);
        chk("vq", vq, mir[8'h15] >> 7);
        w(8'h14, 8'h40);
        m = $urandom % 256;
        c = $urandom % 256;
        w(8'h17, m);
        w(8'h18, c);
        settle(2);
        chk("lvl1", lv1, 4 * (m + c));
        chk("lvl2", lv2, 4 * (m + mir[8'h19]));
        chk("lvl3", lv3, 4 * (m + mir[8'h1A]));
        chk("lvl4", lv4, 4 * (m + mir[8'h1B]));
        w(8'h14, 8'h41);
        settle(2);
        chk("mute", lv1, 11'h7FF);
        chk("sil", sil, 4'h1);
        w(8'h14, 8'h40);
        w(8'h16, 8'h00);
        w(8'h14, 8'h00);
        w(8'h18, c ^ 1);
        settle(1);
        chk("soft", lv1 !== 4 * (m + (c ^ 1)), 1'b1);
        settle(60);
        chk("ramp", lv1, 4 * (m + (c ^ 1)));
        w(8'h1F, 8'h00);
        w(8'h1E, 8'h00);
        pulse(7'h01, 8'h01);
        ci();
        r(8'h21);
        r(8'h1F);
        w(8'h1F, 8'h80);
        pulse(7'h10, 8'h80);
        ci();
        for (int p = 0; p < 4; p++)
        begin
            w(8'h1E, 8'h80 | (p << 5));
            w(8'h1F, 8'h00);
            pulse(7'h20, 8'h60);
            ci();
            r(8'h21);
            r(8'h1F);
            w(8'h1F, 8'hEF);
            pulse(7'h20, 8'h60);
            ci();
            r(8'h21);
        end
        @(posedge clk) frame <= 2'h1;
        mir[8'h21] |= 8'h40;
        settle(2);
        r(8'h21);
        w(8'h15, 8'h0F);
        @(posedge clk) adc_off <= 4'hF;
        @(posedge clk) speed <= 2'h2;
        @(posedge clk) role <= 1'b1;
        settle(2);
        r(8'h21);
        @(posedge clk) adc_off <= 4'h0;
        pulse(7'h60, 0);
        r(8'h21);
        w(8'h15, 8'h8F);
        settle(1);
        chk("vq_set", vq, 1'b1);
        @(posedge clk) rst_n <= 1'b0;
        settle(2);
        chk("vq_rst", vq, 1'b0);
        tally_and_finish();
    end
endmodule
